// *** ias_map.vh ***
`ifndef IAS_MAP_VH
`define IAS_MAP_VH

// clock and timing
`define IAS_CLK_HZ 200000000
`define IAS_AZ_TIME_MS 400
`define IAS_AZ_CYCLES (`IAS_AZ_TIME_MS * (`IAS_CLK_HZ / 1000))
`define IAS_CONV_TIME_MS 320
`define IAS_CONV_CYCLES (`IAS_CONV_TIME_MS * (`IAS_CLK_HZ / 1000))
`define IAS_CALC_CYCLES 32'h00000020
`define IAS_SLOPE_REVERSALS 6'h20
`define IAS_DIV_LAST 5'h16
`define IAS_DIV_DONE 5'h17

// result format, offset binary, one count per fixed step
`define IAS_LSB_STEP_UV 5
`define IAS_RES_W 22
`define IAS_RES_ZERO 22'h200000
`define IAS_RES_NEG_FS 22'h000000
`define IAS_RES_POS_FS 22'h3fffff

// status codes {high, low}
`define IAS_ST_CONVERTING 2'h0
`define IAS_ST_MSB 2'h1
`define IAS_ST_MID 2'h2
`define IAS_ST_READY 2'h3

// register offsets
`define IAS_REG_CTRL 8'h00
`define IAS_REG_STATE 8'h04
`define IAS_REG_RESULT 8'h08
`define IAS_REG_TP 8'h0c
`define IAS_REG_TM 8'h10
`define IAS_REG_IRQ_STAT 8'h14
`define IAS_REG_IRQ_CLR 8'h18
`define IAS_REG_IRQ_EN 8'h1c

// field positions
`define IAS_CTRL_CONVERT 0
`define IAS_CTRL_AUTOZERO 1
`define IAS_IRQ_DONE 0
`define IAS_IRQ_AZ_DONE 1
`define IAS_IRQ_IGNORED 2
`define IAS_IRQ_W 3
`define IAS_IRQ_EN_RESET 3'h0

`endif

// *** ias_sequencer.v ***
// The implementer's own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "ias_map.vh"

// Operation
// - a falling edge on the convert input while ready starts a new conversion cycle.
// - the two status outputs encode converting, msb shown, middle byte shown, lsb shown and ready.
// - when the calculation ends the msb goes into the output buffer, then the low status bit rises.
// - the second convert pulse loads the middle byte and changes the status to high bit only.
// - the third convert pulse loads the lsb and drives both status bits high.
// - the current status code decides whether a convert pulse starts a conversion or steps the bytes.
// - the data port is driven with the buffered byte only while output enable is low, else floated.
// - the output enable input is active low.
// - auto-zero low resets the controller, shorts the inputs, floats then lowers status until done.
// - an auto-zero runs by itself after power-up, and may be requested again later.
// - the result is bipolar offset binary over three bytes, zero input reading 20 00 00.
// - the result is scaled so one count is one fixed input voltage step.
// - the reference current direction reverses on every integrator threshold trip.
// - positive and negative slope times are counted and the result is their difference over sum.
// - each reversal after the first captures the interval count and calculation starts after enough reversals.
// - a conversion reaches result available within the conversion latency of the first pulse.
module ias_sequencer #(
    parameter [31:0] AZ_CYCLES = `IAS_AZ_CYCLES,
    parameter [31:0] CONV_CYCLES = `IAS_CONV_CYCLES
) (
    input wire i_core_clk,
    input wire i_rstn,
    input wire i_wb_cyc,
    input wire i_wb_stb,
    input wire i_wb_we,
    input wire [7:0] i_wb_adr,
    input wire [31:0] i_wb_dat,
    input wire [3:0] i_wb_sel,
    output reg [31:0] o_wb_dat,
    output reg o_wb_ack,
    input wire i_convert_n,
    input wire i_output_enable_n,
    input wire i_auto_zero_reset_n,
    input wire i_slope_trip,
    output reg o_ref_dir,
    output reg o_input_short,
    output reg [7:0] o_data,
    output reg o_data_oe,
    output reg o_status_low_bit,
    output reg o_status_high_bit,
    output reg o_status_oe,
    output reg o_irq
);

    localparam [2:0] S_AZ = 3'h0;
    localparam [2:0] S_MEAS = 3'h1;
    localparam [2:0] S_CALC = 3'h2;
    localparam [2:0] S_MSB = 3'h3;
    localparam [2:0] S_MID = 3'h4;
    localparam [2:0] S_READY = 3'h5;

    // reset release
    reg rst_meta;
    reg rst_sync;
    wire rst_n;

    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end
    assign rst_n = rst_sync;

    // pin synchronisers
    reg conv_meta;
    reg conv_s;
    reg conv_d;
    reg oe_meta;
    reg oe_s;
    reg az_meta;
    reg az_s;
    reg trip_meta;
    reg trip_s;
    reg trip_d;

    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_meta <= 1'b1;
            conv_s <= 1'b1;
            conv_d <= 1'b1;
            oe_meta <= 1'b1;
            oe_s <= 1'b1;
            az_meta <= 1'b1;
            az_s <= 1'b1;
            trip_meta <= 1'b0;
            trip_s <= 1'b0;
            trip_d <= 1'b0;
        end else begin
            conv_meta <= i_convert_n;
            conv_s <= conv_meta;
            conv_d <= conv_s;
            oe_meta <= i_output_enable_n;
            oe_s <= oe_meta;
            az_meta <= i_auto_zero_reset_n;
            az_s <= az_meta;
            trip_meta <= i_slope_trip;
            trip_s <= trip_meta;
            trip_d <= trip_s;
        end
    end

    wire conv_fall = conv_d & ~conv_s;
    wire trip_edge = trip_s & ~trip_d;

    // bus decode
    wire wb_hit = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    wire wb_wr = wb_hit & i_wb_we & i_wb_sel[0];
    wire ctrl_wr = wb_wr && (i_wb_adr == `IAS_REG_CTRL);
    wire sw_convert = ctrl_wr & i_wb_dat[`IAS_CTRL_CONVERT];
    wire sw_az = ctrl_wr & i_wb_dat[`IAS_CTRL_AUTOZERO];
    wire convert_evt = conv_fall | sw_convert;
    wire az_req = ~az_s | sw_az;

    // sequencer state
    reg [2:0] state;
    reg [2:0] state_q;
    reg [31:0] timer;
    reg [31:0] interval;
    reg [31:0] tp_acc;
    reg [31:0] tm_acc;
    reg [5:0] reversals;
    reg armed;
    reg [33:0] rem;
    reg [32:0] sum;
    reg [20:0] quo;
    reg neg;
    reg [4:0] div_cnt;
    reg [21:0] result;
    reg [7:0] data_buf;
    reg evt_done;
    reg evt_az;
    reg evt_ign;

    wire tp_ge = tp_acc >= tm_acc;
    wire [31:0] diff = tp_ge ? (tp_acc - tm_acc) : (tm_acc - tp_acc);
    wire [33:0] rem2 = {rem[32:0], 1'b0};
    wire rem_ge = rem2 >= {1'b0, sum};
    wire last_rev = trip_edge && armed && (reversals == `IAS_SLOPE_REVERSALS - 6'h01);
    wire meas_timeout = timer >= (CONV_CYCLES - `IAS_CALC_CYCLES);

    // reference current direction
    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_ref_dir <= 1'b1;
        end else if (trip_edge) begin
            o_ref_dir <= ~o_ref_dir;
        end
    end

    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_AZ;
            timer <= 32'h0;
            interval <= 32'h0;
            tp_acc <= 32'h0;
            tm_acc <= 32'h0;
            reversals <= 6'h0;
            armed <= 1'b0;
            rem <= 34'h0;
            sum <= 33'h0;
            quo <= 21'h0;
            neg <= 1'b0;
            div_cnt <= 5'h0;
            result <= `IAS_RES_ZERO;
            data_buf <= 8'h00;
            o_input_short <= 1'b1;
            evt_done <= 1'b0;
            evt_az <= 1'b0;
            evt_ign <= 1'b0;
        end else begin
            evt_done <= 1'b0;
            evt_az <= 1'b0;
            evt_ign <= 1'b0;
            if (az_req && state != S_AZ) begin
                state <= S_AZ;
                timer <= 32'h0;
                o_input_short <= 1'b1;
            end else begin
                case (state)
                    S_AZ: begin
                        o_input_short <= 1'b1;
                        if (az_req) begin
                            timer <= 32'h0;
                        end else if (timer >= AZ_CYCLES - 32'h1) begin
                            state <= S_READY;
                            o_input_short <= 1'b0;
                            data_buf <= 8'h00;
                            evt_az <= 1'b1;
                        end else begin
                            timer <= timer + 32'h1;
                        end
                    end
                    S_READY: begin
                        if (convert_evt) begin
                            state <= S_MEAS;
                            timer <= 32'h0;
                            interval <= 32'h0;
                            tp_acc <= 32'h0;
                            tm_acc <= 32'h0;
                            reversals <= 6'h0;
                            armed <= 1'b0;
                        end
                    end
                    S_MEAS: begin
                        timer <= timer + 32'h1;
                        interval <= interval + 32'h1;
                        evt_ign <= convert_evt;
                        if (trip_edge) begin
                            interval <= 32'h1;
                            armed <= 1'b1;
                            if (armed) begin
                                reversals <= reversals + 6'h01;
                                if (o_ref_dir) begin
                                    tp_acc <= tp_acc + interval;
                                end else begin
                                    tm_acc <= tm_acc + interval;
                                end
                            end
                        end
                        if (last_rev || meas_timeout) begin
                            state <= S_CALC;
                            div_cnt <= 5'h0;
                        end
                    end
                    S_CALC: begin
                        evt_ign <= convert_evt;
                        div_cnt <= div_cnt + 5'h01;
                        if (div_cnt == 5'h0) begin
                            rem <= {2'b00, diff};
                            sum <= {1'b0, tp_acc} + {1'b0, tm_acc};
                            neg <= ~tp_ge;
                            quo <= 21'h0;
                        end else if (div_cnt < `IAS_DIV_LAST) begin
                            if (rem_ge) begin
                                rem <= rem2 - {1'b0, sum};
                                quo <= {quo[19:0], 1'b1};
                            end else begin
                                rem <= rem2;
                                quo <= {quo[19:0], 1'b0};
                            end
                        end else if (div_cnt == `IAS_DIV_LAST) begin
                            if (sum == 33'h0) begin
                                result <= `IAS_RES_ZERO;
                            end else if (neg) begin
                                result <= `IAS_RES_ZERO - {1'b0, quo};
                            end else begin
                                result <= `IAS_RES_ZERO + {1'b0, quo};
                            end
                        end else begin
                            data_buf <= {2'b00, result[21:16]};
                            state <= S_MSB;
                            evt_done <= 1'b1;
                        end
                    end
                    S_MSB: begin
                        if (convert_evt) begin
                            data_buf <= result[15:8];
                            state <= S_MID;
                        end
                    end
                    S_MID: begin
                        if (convert_evt) begin
                            data_buf <= result[7:0];
                            state <= S_READY;
                        end
                    end
                    default: begin
                        state <= S_AZ;
                        timer <= 32'h0;
                    end
                endcase
            end
        end
    end

    // status lags data by one cycle so the byte is in place first
    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_AZ;
            o_status_low_bit <= 1'b0;
            o_status_high_bit <= 1'b0;
            o_status_oe <= 1'b0;
            o_data <= 8'h00;
            o_data_oe <= 1'b0;
        end else begin
            state_q <= state;
            o_status_low_bit <= (state_q == S_MSB) | (state_q == S_READY);
            o_status_high_bit <= (state_q == S_MID) | (state_q == S_READY);
            o_status_oe <= az_s;
            o_data <= data_buf;
            o_data_oe <= ~oe_s;
        end
    end

    // interrupt flags, set wins over clear
    reg [`IAS_IRQ_W-1:0] irq_stat;
    reg [`IAS_IRQ_W-1:0] irq_en;
    wire [`IAS_IRQ_W-1:0] irq_evt = {evt_ign, evt_az, evt_done};
    wire [`IAS_IRQ_W-1:0] irq_clr = (wb_wr && i_wb_adr == `IAS_REG_IRQ_CLR) ?
        i_wb_dat[`IAS_IRQ_W-1:0] : {`IAS_IRQ_W{1'b0}};

    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat <= {`IAS_IRQ_W{1'b0}};
            irq_en <= `IAS_IRQ_EN_RESET;
            o_irq <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
            if (wb_wr && i_wb_adr == `IAS_REG_IRQ_EN) begin
                irq_en <= i_wb_dat[`IAS_IRQ_W-1:0];
            end
            o_irq <= |(irq_stat & irq_en);
        end
    end

    // register read
    reg [31:0] rd_data;

    always @* begin
        case (i_wb_adr)
            `IAS_REG_STATE: rd_data = {27'h0, o_status_high_bit, o_status_low_bit, state};
            `IAS_REG_RESULT: rd_data = {10'h0, result};
            `IAS_REG_TP: rd_data = tp_acc;
            `IAS_REG_TM: rd_data = tm_acc;
            `IAS_REG_IRQ_STAT: rd_data = {29'h0, irq_stat};
            `IAS_REG_IRQ_EN: rd_data = {29'h0, irq_en};
            default: rd_data = 32'h0;
        endcase
    end

    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0;
        end else begin
            o_wb_ack <= wb_hit;
            if (wb_hit) begin
                o_wb_dat <= rd_data;
            end
        end
    end

endmodule // ias_sequencer

`default_nettype wire

// *** ias_chk_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module ias_chk #(
    parameter [31:0] AZ_CYCLES = 32'h14,
    parameter [31:0] CONV_CYCLES = 32'hfa0
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_convert_n,
    input wire logic i_output_enable_n,
    input wire logic i_auto_zero_reset_n,
    input wire logic i_slope_trip,
    input wire logic o_ref_dir,
    input wire logic [7:0] o_data,
    input wire logic o_data_oe,
    input wire logic o_status_low_bit,
    input wire logic o_status_high_bit,
    input wire logic o_status_oe
);
    localparam [31:0] LIM = (AZ_CYCLES > CONV_CYCLES ? AZ_CYCLES : CONV_CYCLES) + 32'h40;
    wire [1:0] st = {o_status_high_bit, o_status_low_bit};
    logic [31:0] busy;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);
    // cycles in a driven 00 code
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) busy <= 32'h0;
        else busy <= (st == 2'h0 && o_status_oe) ? busy + 32'h1 : 32'h0;
    end
    sequence s_fall(logic [1:0] c);
        $fell(i_convert_n) && o_status_oe && st == c;
    endsequence
    sequence s_code(logic [1:0] c);
        ##[1:8] st == c;
    endsequence
    property p_start;
        s_fall(2'h3) |-> s_code(2'h0);
    endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_mid;
        s_fall(2'h1) |-> s_code(2'h2);
    endproperty
    a_mid: assert property (p_mid) else $error("no middle byte");
    property p_lsb;
        s_fall(2'h2) |-> s_code(2'h3);
    endproperty
    a_lsb: assert property (p_lsb) else $error("no low byte");
    property p_msb;
        st == 2'h1 && $past(st) == 2'h0 |-> $stable(o_data) && o_data[7:6] == 2'h0;
    endproperty
    a_msb: assert property (p_msb) else $error("msb not ahead");
    property p_ign;
        s_fall(2'h0) |-> (st == 2'h0) [*6];
    endproperty
    a_ign: assert property (p_ign) else $error("pulse not ignored");
    property p_oe;
        !i_output_enable_n [*6] |-> o_data_oe;
    endproperty
    a_oe: assert property (p_oe) else $error("port not driven");
    property p_az;
        !i_auto_zero_reset_n [*6] |-> !o_status_oe && st == 2'h0;
    endproperty
    a_az: assert property (p_az) else $error("status not floated");
    property p_trip;
        $rose(i_slope_trip) |-> ##[1:6] $changed(o_ref_dir);
    endproperty
    a_trip: assert property (p_trip) else $error("no reversal");
    property p_time;
        busy <= LIM;
    endproperty
    a_time: assert property (p_time) else $error("conversion too long");
endmodule // ias_chk
bind ias_sequencer ias_chk #(.AZ_CYCLES(AZ_CYCLES), .CONV_CYCLES(CONV_CYCLES)) u_chk (.*);
`default_nettype wire

// *** ias_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ias_host_model (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic i_oe_req,
    input wire logic [7:0] i_data,
    input wire logic i_data_oe,
    output logic o_convert_n,
    output logic o_output_enable_n,
    output logic [7:0] o_pin
);
    logic [3:0] cnt = 4'h0;
    logic [7:0] last = 8'h0;
    initial o_output_enable_n = 1'b1;
    // falling convert edge, 4 cycles low then 4 high
    always @(posedge i_clk) begin
        o_output_enable_n <= !i_oe_req;
        if (i_data_oe) last <= i_data;
        if (i_go && cnt == 4'h0) cnt <= 4'h8;
        else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    end
    assign o_convert_n = cnt <= 4'h4;
    // released port shows the inverse of the last byte
    assign o_pin = i_data_oe ? i_data : ~last;
endmodule // ias_host_model
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ias_map.vh"
module tb_top;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h0;
    logic [31:0] wdat = 32'h0;
    logic azn = 1'b1;
    logic trip = 1'b0;
    logic go = 1'b0;
    logic oe_req = 1'b0;
    logic trip_on = 1'b0;
    logic [1:0] hold = 2'h0;
    logic [7:0] tcnt = 8'h0;
    int tp = 40;
    int tm = 40;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    wire [31:0] rdat;
    wire [7:0] data, pin;
    wire ack, convn, oen, dir, shrt, doe, slo, shi, soe, irq;
    always #2.5 clk = ~clk;
    ias_sequencer #(.AZ_CYCLES(32'h14), .CONV_CYCLES(32'hfa0)) dut (
        .i_core_clk(clk), .i_rstn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_convert_n(convn), .i_output_enable_n(oen), .i_auto_zero_reset_n(azn),
        .i_slope_trip(trip), .o_ref_dir(dir), .o_input_short(shrt), .o_data(data),
        .o_data_oe(doe), .o_status_low_bit(slo), .o_status_high_bit(shi),
        .o_status_oe(soe), .o_irq(irq));
    ias_host_model host (.i_clk(clk), .i_go(go), .i_oe_req(oe_req), .i_data(data),
        .i_data_oe(doe), .o_convert_n(convn), .o_output_enable_n(oen), .o_pin(pin));
    // integrator: next slope length picked from the direction just ended
    always @(posedge clk) begin
        hold <= {hold[0], trip_on && tcnt == 8'h0};
        trip <= (trip_on && tcnt == 8'h0) || hold != 2'h0;
        if (!trip_on || tcnt == 8'h0) tcnt <= dir ? tm[7:0] - 8'h1 : tp[7:0] - 8'h1;
        else tcnt <= tcnt - 8'h1;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            wrap_up();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wait_st(input logic [1:0] s);
        int n;
        n = 0;
        while ({shi, slo} !== s && n < 6000) begin
            @(posedge clk);
            n++;
        end
        chk("status", {30'h0, s}, {30'h0, shi, slo});
    endtask
    task automatic pulse();
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (9) @(posedge clk);
    endtask
    task automatic rd_pin(input string nm, input logic [7:0] e);
        @(posedge clk);
        oe_req <= 1'b1;
        repeat (7) @(posedge clk);
        chk(nm, {24'h0, e}, {24'h0, pin});
        oe_req <= 1'b0;
        repeat (7) @(posedge clk);
    endtask
    function automatic logic [21:0] exp_res(input int p, input int m);
        longint mag;
        mag = (longint'(p > m ? p - m : m - p) * 64'h200000) / (p + m);
        return p >= m ? 22'h200000 + mag[21:0] : 22'h200000 - mag[21:0];
    endfunction
    task automatic conv(input int p, input int m, input bit extra);
        logic [21:0] e;
        logic [31:0] q;
        e = exp_res(p, m);
        tp = p;
        tm = m;
        pulse();
        wait_st(2'h0);
        if (extra) pulse();
        wait_st(2'h1);
        rd_pin("msb", {2'h0, e[21:16]});
        wb(1'b0, `IAS_REG_RESULT, 32'h0, q);
        chk("result", {10'h0, e}, q);
        pulse();
        wait_st(2'h2);
        rd_pin("mid", e[15:8]);
        pulse();
        wait_st(2'h3);
        rd_pin("lsb", e[7:0]);
    endtask
    initial begin
        logic [31:0] q;
        void'($urandom(99));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        wait_st(2'h3);
        trip_on <= 1'b1;
        wb(1'b0, `IAS_REG_IRQ_EN, 32'h0, q);
        chk("irq_en", 32'h0, q);
        wb(1'b1, `IAS_REG_IRQ_CLR, 32'h7, q);
        wb(1'b1, `IAS_REG_IRQ_EN, 32'h1, q);
        conv(40, 40, 1'b1);
        wb(1'b0, `IAS_REG_IRQ_STAT, 32'h0, q);
        chk("irq_stat", 32'h5, q);
        chk("irq", 32'h1, {31'h0, irq});
        wb(1'b1, `IAS_REG_IRQ_CLR, 32'h7, q);
        wb(1'b1, `IAS_REG_IRQ_EN, 32'h0, q);
        chk("irq", 32'h0, {31'h0, irq});
        conv(120, 8, 1'b0);
        chk("irq", 32'h0, {31'h0, irq});
        for (int i = 0; i < 3; i++) conv(8 + $urandom % 63, 8 + $urandom % 63, 1'b0);
        wb(1'b0, 8'h40, 32'h0, q);
        chk("unmapped", 32'h0, q);
        azn <= 1'b0;
        repeat (10) @(posedge clk);
        chk("status_oe", 32'h0, {31'h0, soe});
        chk("short", 32'h1, {31'h0, shrt});
        azn <= 1'b1;
        wait_st(2'h3);
        wb(1'b0, `IAS_REG_IRQ_STAT, 32'h0, q);
        chk("az_done", 32'h2, q & 32'h2);
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
